// *** design/cswf_charge_ctl.sv ***
`timescale 1ns/100ps
`default_nettype none

module cswf_charge_ctl
  import cswf_pkg::*;
(
  input wire logic mclk_in,                  // 40 MHz clock
  input wire logic rst_in,                   // Async reset, high
  cswf_ctl_if.ctl link,                      // Word writes, status
  input wire logic input_power_flag_in,      // Charge power present
  input wire logic battery_present_in,       // Battery detected
  input wire logic sensor_open_flag_in,      // Thermistor overrange
  input wire logic sensor_low_temp_flag_in,  // Thermistor cold
  input wire logic sensor_high_temp_flag_in, // Thermistor hot
  input wire logic [15:0] amp_limit_in,      // Current ceiling
  input wire logic [15:0] volt_limit_in,     // Voltage ceiling
  output logic irq_n_out,                    // Status change, low
  output logic charge_enable_out,            // Charger may run
  output logic [15:0] amp_setting_out,       // Current DAC word
  output logic [15:0] volt_setting_out       // Voltage DAC word
);

  typedef struct packed {
    logic inhibit;
    logic block;
    logic got_amp;
    logic got_volt;
    logic loaded;
    logic amp_or;
    logic volt_or;
    logic chg_en;
    logic irq_n;
    logic [15:0] amp_req;
    logic [15:0] volt_req;
    logic [15:0] amp_set;
    logic [15:0] volt_set;
    logic [15:0] stat;
  } cswf_ctl_t;

  localparam cswf_ctl_t CTL_RST =
    '{irq_n: 1'b1, stat: CSWF_STAT_RESET, default: '0};

  cswf_ctl_t q;
  cswf_ctl_t d;
  logic [15:0] s;

  always_comb begin
    s = '0;
    s[CSWF_ST_INHIBIT] = q.inhibit;
    s[CSWF_ST_LEVEL +: 2] = CSWF_LEVEL_CODE;
    s[CSWF_ST_AMP_OR] = q.amp_or;
    s[CSWF_ST_VOLT_OR] = q.volt_or;
    s[CSWF_ST_OPEN] = sensor_open_flag_in;
    s[CSWF_ST_COLD] = sensor_low_temp_flag_in;
    s[CSWF_ST_HOT] = sensor_high_temp_flag_in;
    d = q;
    d.stat = s;
    if (link.rd_done) begin
      d.irq_n = 1'b1;
    end
    // A change in the same cycle as the read keeps the line low
    if (s != q.stat) begin
      d.irq_n = 1'b0;
    end
    if (q.got_amp && q.got_volt) begin
      d.amp_set = q.amp_req;
      d.volt_set = q.volt_req;
      d.loaded = 1'b1;
      d.block = 1'b0;
      d.got_amp = 1'b0;
      d.got_volt = 1'b0;
    end
    if (link.amp_wr) begin
      d.got_amp = 1'b1;
      d.amp_or = link.wdata > amp_limit_in;
      d.amp_req = d.amp_or ? amp_limit_in : link.wdata;
    end
    if (link.volt_wr) begin
      d.got_volt = 1'b1;
      d.volt_or = link.wdata > volt_limit_in;
      d.volt_req = d.volt_or ? volt_limit_in : link.wdata;
    end
    if (link.mode_wr) begin
      // Polling request and upper bits have no effect
      d.inhibit = link.wdata[CSWF_MODE_INHIBIT];
      if (link.wdata[CSWF_MODE_CLEAR]) begin
        d.block = 1'b1;
        d.got_amp = 1'b0;
        d.got_volt = 1'b0;
      end
      if (link.wdata[CSWF_MODE_DEFAULTS]) begin
        // Only the controller state; bus engine and interrupt stay
        d.inhibit = 1'b0;
        d.block = 1'b0;
        d.got_amp = 1'b0;
        d.got_volt = 1'b0;
        d.loaded = 1'b0;
        d.amp_or = 1'b0;
        d.volt_or = 1'b0;
        d.amp_req = '0;
        d.volt_req = '0;
        d.amp_set = '0;
        d.volt_set = '0;
      end
    end
    if (!input_power_flag_in || !battery_present_in) begin
      d.inhibit = 1'b0;
    end
    d.chg_en = q.loaded && !q.block && !q.inhibit && input_power_flag_in
      && battery_present_in && !sensor_open_flag_in
      && !sensor_high_temp_flag_in;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= CTL_RST;
    end else begin
      q <= d;
    end
  end

  assign link.status = q.stat;
  assign link.irq_n = q.irq_n;
  assign irq_n_out = q.irq_n;
  assign charge_enable_out = q.chg_en;
  assign amp_setting_out = q.amp_set;
  assign volt_setting_out = q.volt_set;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_clear_req;
    link.mode_wr && link.wdata[CSWF_MODE_CLEAR]
      && !link.wdata[CSWF_MODE_DEFAULTS];
  endsequence

  a_inhibit_takes: assert property (
    link.mode_wr && link.wdata[CSWF_MODE_INHIBIT]
      && !link.wdata[CSWF_MODE_DEFAULTS]
      && input_power_flag_in && battery_present_in
    |=> q.inhibit ##1 q.stat[CSWF_ST_INHIBIT])
    else $error("inhibit bit not taken or not reported");
  a_inhibit_drop: assert property (
    !input_power_flag_in || !battery_present_in |=> !q.inhibit)
    else $error("inhibit not cleared without power or battery");
  a_defaults_restore: assert property (
    link.mode_wr && link.wdata[CSWF_MODE_DEFAULTS]
    |=> !q.loaded && !q.inhibit && q.amp_set == '0 && q.volt_set == '0)
    else $error("controller defaults not restored");
  a_clear_blocks: assert property (
    s_clear_req |=> q.block ##1 !q.chg_en)
    else $error("charging not blocked after clear request");
  a_fixed_status_bits: assert property (
    q.stat[CSWF_ST_LEVEL +: 2] == CSWF_LEVEL_CODE && !q.stat[CSWF_ST_MASTER]
      && !q.stat[CSWF_ST_VUNREG] && !q.stat[CSWF_ST_AUNREG])
    else $error("fixed status bits wrong");
  a_amp_clamp: assert property (
    link.amp_wr && link.wdata > amp_limit_in
    |=> q.amp_or && q.amp_req == $past(amp_limit_in))
    else $error("current request not clamped");
  a_volt_flag: assert property (
    link.volt_wr
    |=> q.volt_or == ($past(link.wdata) > $past(volt_limit_in)))
    else $error("voltage overrange flag wrong");
  a_sensor_live: assert property (
    ##1 q.stat[CSWF_ST_HOT] == $past(sensor_high_temp_flag_in)
      && q.stat[CSWF_ST_OPEN] == $past(sensor_open_flag_in))
    else $error("sensor flags not live");
  a_irq_on_change: assert property (
    d.stat != q.stat |=> !q.irq_n)
    else $error("no interrupt on status change");

endmodule

`default_nettype wire

// *** design/cswf_word_regs.sv ***
`timescale 1ns/100ps
`default_nettype none

module cswf_word_regs
  import cswf_pkg::*;
(
  input wire logic mclk_in,                  // 40 MHz clock
  input wire logic rst_in,                   // Async reset, high
  input wire logic scl_in,                   // Bus clock level
  input wire logic sda_in,                   // Bus data level
  output logic sda_out,                      // Data value when driven
  output logic sda_oe_out,                   // Pull data low
  input wire logic input_power_flag_in,      // Charge power present
  input wire logic battery_present_in,       // Battery detected
  input wire logic sensor_open_flag_in,      // Thermistor overrange
  input wire logic sensor_low_temp_flag_in,  // Thermistor cold
  input wire logic sensor_high_temp_flag_in, // Thermistor hot
  input wire logic [15:0] amp_limit_in,      // Current ceiling
  input wire logic [15:0] volt_limit_in,     // Voltage ceiling
  output logic status_change_irq_n_out,      // Status change, low
  output logic charge_enable_out,            // Charger may run
  output logic [15:0] amp_setting_out,       // Current DAC word
  output logic [15:0] volt_setting_out       // Voltage DAC word
);

  // ----------------------------------------------------------------
  // Byte engine state
  // ----------------------------------------------------------------
  typedef struct packed {
    cswf_state_t st;
    logic scl;
    logic sda;
    logic [7:0] sh;
    logic [3:0] bits;
    logic [2:0] idx;
    logic [7:0] cmd;
    logic has_cmd;
    logic [7:0] tb;
    logic [7:0] hi;
    logic [7:0] lo;
    logic tx_hi;
    logic ara;
    logic nxt_tx;
    logic nak;
    logic sda_oe;
    logic sda_lvl;
    logic mode_wr;
    logic amp_wr;
    logic volt_wr;
    logic rd_done;
    logic [15:0] wdata;
  } cswf_bus_t;

  localparam cswf_bus_t BUS_RST =
    '{st: CSWF_IDLE, scl: 1'b1, sda: 1'b1, default: '0};

  cswf_bus_t q;
  cswf_bus_t d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_end;
  logic [15:0] rd_word;

  cswf_ctl_if link ();

  function automatic logic cswf_known(input logic [7:0] c);
    return c == CSWF_CMD_CAP || c == CSWF_CMD_MODE || c == CSWF_CMD_STAT
      || c == CSWF_CMD_AMP || c == CSWF_CMD_VOLT;
  endfunction

  function automatic logic cswf_readable(input logic [7:0] c);
    return c == CSWF_CMD_CAP || c == CSWF_CMD_STAT;
  endfunction

  function automatic logic cswf_writable(input logic [7:0] c);
    return c == CSWF_CMD_MODE || c == CSWF_CMD_AMP || c == CSWF_CMD_VOLT;
  endfunction

  // ----------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------
  assign scl_rise = scl_in && !q.scl;
  assign scl_fall = !scl_in && q.scl;
  assign start_seen = scl_in && q.scl && q.sda && !sda_in;
  assign stop_seen = scl_in && q.scl && !q.sda && sda_in;
  assign byte_end = q.st == CSWF_RX && scl_fall
    && q.bits == CSWF_BYTE_BITS;

  // Whole word is captured when the read is addressed, so both bytes
  // come from one status snapshot
  assign rd_word = (q.cmd == CSWF_CMD_STAT) ? link.status
    : CSWF_CAP_WORD;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.scl = scl_in;
    d.sda = sda_in;
    d.sda_lvl = 1'b0;
    d.mode_wr = 1'b0;
    d.amp_wr = 1'b0;
    d.volt_wr = 1'b0;
    d.rd_done = 1'b0;
    if (start_seen) begin
      // Repeated start keeps the command for the read that follows
      d.st = CSWF_RX;
      d.bits = '0;
      d.idx = CSWF_IDX_ADDR;
      d.sda_oe = 1'b0;
    end else if (stop_seen) begin
      d.st = CSWF_IDLE;
      d.has_cmd = 1'b0;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        CSWF_IDLE, CSWF_WAIT: begin
          d.sda_oe = 1'b0;
        end
        CSWF_RX: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], sda_in};
            d.bits = q.bits + 4'h1;
          end else if (byte_end) begin
            d.st = CSWF_ACK;
            d.bits = '0;
            d.nak = 1'b0;
            d.nxt_tx = 1'b0;
            d.sda_oe = 1'b1;
            unique case (q.idx)
              CSWF_IDX_ADDR: begin
                if (q.sh == {CSWF_OWN_ADDR, 1'b0}) begin
                  d.idx = CSWF_IDX_CMD;
                end else if (q.sh == {CSWF_OWN_ADDR, 1'b1} && q.has_cmd
                    && cswf_readable(q.cmd)) begin
                  d.nxt_tx = 1'b1;
                  d.tx_hi = 1'b0;
                  d.ara = 1'b0;
                  d.tb = rd_word[7:0];
                  d.hi = rd_word[15:8];
                end else if (q.sh == {CSWF_ARA_ADDR, 1'b1}
                    && !link.irq_n) begin
                  d.nxt_tx = 1'b1;
                  d.tx_hi = 1'b0;
                  d.ara = 1'b1;
                  d.tb = CSWF_ARA_REPLY;
                end else begin
                  d.nak = 1'b1;
                  d.sda_oe = 1'b0;
                end
              end
              CSWF_IDX_CMD: begin
                if (cswf_known(q.sh)) begin
                  d.cmd = q.sh;
                  d.has_cmd = 1'b1;
                  d.idx = CSWF_IDX_LO;
                end else begin
                  d.nak = 1'b1;
                  d.sda_oe = 1'b0;
                end
              end
              CSWF_IDX_LO: begin
                if (cswf_writable(q.cmd)) begin
                  d.lo = q.sh;
                  d.idx = CSWF_IDX_HI;
                end else begin
                  d.nak = 1'b1;
                  d.sda_oe = 1'b0;
                end
              end
              CSWF_IDX_HI: begin
                d.wdata = {q.sh, q.lo};
                d.idx = CSWF_IDX_OVER;
                d.mode_wr = q.cmd == CSWF_CMD_MODE;
                d.amp_wr = q.cmd == CSWF_CMD_AMP;
                d.volt_wr = q.cmd == CSWF_CMD_VOLT;
              end
              default: begin
                d.nak = 1'b1;
                d.sda_oe = 1'b0;
              end
            endcase
          end
        end
        CSWF_ACK: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            if (q.nak) begin
              d.st = CSWF_WAIT;
            end else if (q.nxt_tx) begin
              d.st = CSWF_TX;
              d.sda_oe = !q.tb[7];
              d.tb = {q.tb[6:0], 1'b0};
              d.bits = 4'h1;
            end else begin
              d.st = CSWF_RX;
              d.bits = '0;
            end
          end
        end
        CSWF_TX: begin
          if (scl_fall) begin
            if (q.bits == CSWF_BYTE_BITS) begin
              d.st = CSWF_MACK;
              d.sda_oe = 1'b0;
            end else begin
              d.sda_oe = !q.tb[7];
              d.tb = {q.tb[6:0], 1'b0};
              d.bits = q.bits + 4'h1;
            end
          end
        end
        CSWF_MACK: begin
          if (scl_rise) begin
            if (!sda_in && !q.tx_hi && !q.ara) begin
              d.tx_hi = 1'b1;
              d.tb = q.hi;
              d.st = CSWF_ACK;
              d.nxt_tx = 1'b1;
              d.nak = 1'b0;
            end else begin
              // Master ack or nack both close a complete read
              d.rd_done = q.ara
                || (q.tx_hi && q.cmd == CSWF_CMD_STAT);
              d.st = CSWF_WAIT;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= BUS_RST;
    end else begin
      q <= d;
    end
  end

  assign sda_out = q.sda_lvl;
  assign sda_oe_out = q.sda_oe;
  assign link.mode_wr = q.mode_wr;
  assign link.amp_wr = q.amp_wr;
  assign link.volt_wr = q.volt_wr;
  assign link.rd_done = q.rd_done;
  assign link.wdata = q.wdata;

  // ----------------------------------------------------------------
  // Charger controller
  // ----------------------------------------------------------------
  cswf_charge_ctl u_ctl (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .link(link.ctl),
    .input_power_flag_in(input_power_flag_in),
    .battery_present_in(battery_present_in),
    .sensor_open_flag_in(sensor_open_flag_in),
    .sensor_low_temp_flag_in(sensor_low_temp_flag_in),
    .sensor_high_temp_flag_in(sensor_high_temp_flag_in),
    .amp_limit_in(amp_limit_in),
    .volt_limit_in(volt_limit_in),
    .irq_n_out(status_change_irq_n_out),
    .charge_enable_out(charge_enable_out),
    .amp_setting_out(amp_setting_out),
    .volt_setting_out(volt_setting_out)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_cap_read_addr;
    byte_end && q.idx == CSWF_IDX_ADDR && q.sh == {CSWF_OWN_ADDR, 1'b1}
      && q.has_cmd && q.cmd == CSWF_CMD_CAP;
  endsequence

  sequence s_mode_hi_byte;
    byte_end && q.idx == CSWF_IDX_HI && q.cmd == CSWF_CMD_MODE;
  endsequence

  a_cap_word_load: assert property (
    s_cap_read_addr |=> q.sda_oe && q.tb == CSWF_CAP_WORD[7:0]
      && q.hi == CSWF_CAP_WORD[15:8])
    else $error("capability word not loaded");
  a_ro_write_nak: assert property (
    byte_end && q.idx == CSWF_IDX_LO && cswf_readable(q.cmd)
    |=> !q.sda_oe && q.nak)
    else $error("write to read-only word acknowledged");
  a_wo_read_nak: assert property (
    byte_end && q.idx == CSWF_IDX_ADDR
      && q.sh == {CSWF_OWN_ADDR, 1'b1} && q.cmd == CSWF_CMD_MODE
    |=> !q.sda_oe && q.nak)
    else $error("read of mode word acknowledged");
  a_mode_commit: assert property (
    s_mode_hi_byte |=> link.mode_wr ##1 !link.mode_wr)
    else $error("mode write not a single pulse");
  a_low_byte_first: assert property (
    byte_end && q.idx == CSWF_IDX_HI
    |=> q.wdata == {$past(q.sh), $past(q.lo)})
    else $error("word bytes out of order");
  a_nak_releases: assert property (
    q.st == CSWF_ACK && q.nak |-> !q.sda_oe)
    else $error("data driven during not-acknowledge");

endmodule

`default_nettype wire

// *** inc/cswf_ctl_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface cswf_ctl_if;
  logic mode_wr;
  logic amp_wr;
  logic volt_wr;
  logic rd_done;
  logic [15:0] wdata;
  logic [15:0] status;
  logic irq_n;

  modport bus (
    output mode_wr, amp_wr, volt_wr, rd_done, wdata,
    input status, irq_n
  );
  modport ctl (
    input mode_wr, amp_wr, volt_wr, rd_done, wdata,
    output status, irq_n
  );
endinterface

`default_nettype wire

// *** inc/cswf_pkg.sv ***
package cswf_pkg;

  // ----------------------------------------------------------------
  // Bus addresses and command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] CSWF_OWN_ADDR = 7'h09;
  localparam logic [6:0] CSWF_ARA_ADDR = 7'h0c;
  localparam logic [7:0] CSWF_ARA_REPLY = 8'h89;
  localparam logic [7:0] CSWF_CMD_CAP = 8'h11;
  localparam logic [7:0] CSWF_CMD_MODE = 8'h12;
  localparam logic [7:0] CSWF_CMD_STAT = 8'h13;
  localparam logic [7:0] CSWF_CMD_AMP = 8'h14;
  localparam logic [7:0] CSWF_CMD_VOLT = 8'h15;

  // ----------------------------------------------------------------
  // Capability word
  // ----------------------------------------------------------------
  localparam logic [3:0] CSWF_SPEC_VERSION = 4'h1;
  localparam logic CSWF_SELECTOR_SUPPORT = 1'h0;
  localparam logic [10:0] CSWF_CAP_RSVD = 11'h000;
  localparam logic [15:0] CSWF_CAP_WORD =
    {CSWF_CAP_RSVD, CSWF_SELECTOR_SUPPORT, CSWF_SPEC_VERSION};

  // ----------------------------------------------------------------
  // Mode word bit positions
  // ----------------------------------------------------------------
  localparam int CSWF_MODE_INHIBIT = 0;
  localparam int CSWF_MODE_POLL = 1;
  localparam int CSWF_MODE_DEFAULTS = 2;
  localparam int CSWF_MODE_CLEAR = 3;

  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int CSWF_ST_INHIBIT = 0;
  localparam int CSWF_ST_MASTER = 1;
  localparam int CSWF_ST_VUNREG = 2;
  localparam int CSWF_ST_AUNREG = 3;
  localparam int CSWF_ST_LEVEL = 4;
  localparam int CSWF_ST_AMP_OR = 6;
  localparam int CSWF_ST_VOLT_OR = 7;
  localparam int CSWF_ST_OPEN = 8;
  localparam int CSWF_ST_COLD = 9;
  localparam int CSWF_ST_HOT = 10;
  localparam logic [1:0] CSWF_LEVEL_CODE = 2'h1;
  localparam logic [15:0] CSWF_STAT_RESET = 16'h0010;

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  localparam logic [3:0] CSWF_BYTE_BITS = 4'h8;
  localparam logic [2:0] CSWF_IDX_ADDR = 3'h0;
  localparam logic [2:0] CSWF_IDX_CMD = 3'h1;
  localparam logic [2:0] CSWF_IDX_LO = 3'h2;
  localparam logic [2:0] CSWF_IDX_HI = 3'h3;
  localparam logic [2:0] CSWF_IDX_OVER = 3'h4;

  typedef enum logic [2:0] {
    CSWF_IDLE,
    CSWF_RX,
    CSWF_ACK,
    CSWF_TX,
    CSWF_MACK,
    CSWF_WAIT
  } cswf_state_t;

endpackage

// *** testbench/cswf_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module cswf_host_model
  import cswf_pkg::*;
(
  input wire logic clk_in, // Bench clock
  input wire logic sda_in, // Resolved data line
  output logic scl_out,    // 1 releases the clock line
  output logic sda_out     // 1 releases the data line
);
  initial begin
    scl_out = 1'h1;
    sda_out = 1'h1;
  end

  // ----------------------------------------
  // Line phases
  // ----------------------------------------
  // Four clocks a phase so each level is sampled several times
  task automatic st(input logic c, input logic d);
    repeat (4) @(posedge clk_in);
    #1 scl_out = c;
    sda_out = d;
  endtask
  task automatic start();
    st(1'h0, 1'h1);
    st(1'h1, 1'h1);
    st(1'h1, 1'h0);
    st(1'h0, 1'h0);
  endtask
  task automatic stop();
    st(1'h0, 1'h0);
    st(1'h1, 1'h0);
    st(1'h1, 1'h1);
  endtask
  task automatic bit_w(input logic b);
    st(1'h0, b);
    st(1'h1, b);
    st(1'h0, b);
  endtask
  task automatic bit_r(output logic b);
    st(1'h0, 1'h1);
    st(1'h1, 1'h1);
    repeat (2) @(posedge clk_in);
    b = sda_in;
    st(1'h0, 1'h1);
  endtask
  task automatic byte_w(input logic [7:0] v, output logic a);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_w(v[i]);
    end
    bit_r(b);
    a = (b === 1'h0);
  endtask
  task automatic byte_r(output logic [7:0] v, input logic last);
    for (int i = 7; i >= 0; i--) begin
      bit_r(v[i]);
    end
    bit_w(last);
  endtask

  // ----------------------------------------
  // Word transfers
  // ----------------------------------------
  task automatic wr(input logic [7:0] c, input logic [15:0] w,
                    output logic ok);
    logic [3:0] a;
    start();
    byte_w({CSWF_OWN_ADDR, 1'h0}, a[0]);
    byte_w(c, a[1]);
    byte_w(w[7:0], a[2]);
    byte_w(w[15:8], a[3]);
    stop();
    ok = &a;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] w,
                    output logic ok);
    logic [2:0] a;
    start();
    byte_w({CSWF_OWN_ADDR, 1'h0}, a[0]);
    byte_w(c, a[1]);
    start();
    byte_w({CSWF_OWN_ADDR, 1'h1}, a[2]);
    byte_r(w[7:0], 1'h0);
    byte_r(w[15:8], 1'h1);
    stop();
    ok = &a;
  endtask
  // Alert response read: one byte, master nacks it
  task automatic ara(output logic [7:0] v, output logic ok);
    start();
    byte_w({CSWF_ARA_ADDR, 1'h1}, ok);
    byte_r(v, 1'h1);
    stop();
  endtask
endmodule

`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none

module testbench
  import cswf_pkg::*;
;
  logic mclk_in = 1'h0;
  logic rst_in = 1'h1;
  logic pwr = 1'h1;
  logic bat = 1'h1;
  logic [2:0] sens = 3'h0;
  logic scl, sda_h, oe, irq_n, en, ok, lvl;
  logic [15:0] amp, volt, w;
  int n_mismatch = 0;
  int samples_checked = 0;
  wire sda = sda_h & ~oe;

  always #12.5 mclk_in = ~mclk_in;

  cswf_word_regs dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(lvl), .sda_oe_out(oe), .input_power_flag_in(pwr),
    .battery_present_in(bat), .sensor_open_flag_in(sens[0]),
    .sensor_low_temp_flag_in(sens[1]),
    .sensor_high_temp_flag_in(sens[2]), .amp_limit_in(16'h0800),
    .volt_limit_in(16'h4000), .status_change_irq_n_out(irq_n),
    .charge_enable_out(en), .amp_setting_out(amp),
    .volt_setting_out(volt));
  cswf_host_model host (.clk_in(mclk_in), .sda_in(sda),
    .scl_out(scl), .sda_out(sda_h));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input string s, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chk1(input string s, input logic e, g);
    chk(s, {15'h0, e}, {15'h0, g});
  endtask
  task automatic wr_ok(input logic [7:0] c, input logic [15:0] v);
    host.wr(c, v, ok);
    chk1("ack", 1'h1, ok);
  endtask
  task automatic stat(input logic i, a, v);
    host.rd(CSWF_CMD_STAT, w, ok);
    chk1("stat rd", 1'h1, ok);
    chk("status", {5'h00, sens, v, a, 2'h1, 3'h0, i}, w);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_caps();
    host.rd(CSWF_CMD_CAP, w, ok);
    chk1("cap rd", 1'h1, ok);
    chk("cap", 16'h0001, w);
    chk1("sda level", 1'h0, lvl);
    host.wr(CSWF_CMD_CAP, 16'hffff, ok);
    chk1("cap wr", 1'h0, ok);
    host.wr(CSWF_CMD_STAT, 16'hffff, ok);
    chk1("stat wr", 1'h0, ok);
    host.rd(CSWF_CMD_MODE, w, ok);
    chk1("mode rd", 1'h0, ok);
    stat(1'h0, 1'h0, 1'h0);
  endtask
  task automatic t_mode();
    wr_ok(CSWF_CMD_MODE, 16'h0001);
    chk1("irq", 1'h0, irq_n);
    stat(1'h1, 1'h0, 1'h0);
    chk1("irq", 1'h1, irq_n);
    wr_ok(CSWF_CMD_MODE, 16'hfff3);
    stat(1'h1, 1'h0, 1'h0);
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk_in);
      #1 {pwr, bat} = i ? 2'h1 : 2'h2;
      repeat (4) @(posedge mclk_in);
      #1 {pwr, bat} = 2'h3;
      stat(1'h0, 1'h0, 1'h0);
      wr_ok(CSWF_CMD_MODE, 16'h0001);
    end
    wr_ok(CSWF_CMD_MODE, 16'h0005);
    stat(1'h0, 1'h0, 1'h0);
  endtask
  task automatic t_pair();
    wr_ok(CSWF_CMD_AMP, 16'h0900);
    chk1("en", 1'h0, en);
    wr_ok(CSWF_CMD_VOLT, 16'h3000);
    chk("amp", 16'h0800, amp);
    chk("volt", 16'h3000, volt);
    chk1("en", 1'h1, en);
    stat(1'h0, 1'h1, 1'h0);
    wr_ok(CSWF_CMD_MODE, 16'h0001);
    chk1("en", 1'h0, en);
    wr_ok(CSWF_CMD_MODE, 16'h0008);
    wr_ok(CSWF_CMD_AMP, 16'h0100);
    chk1("en", 1'h0, en);
    wr_ok(CSWF_CMD_VOLT, 16'h5000);
    chk1("en", 1'h1, en);
    chk("volt", 16'h4000, volt);
    stat(1'h0, 1'h0, 1'h1);
  endtask
  task automatic t_sens();
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_in);
      #1 sens = 3'h1 << i;
      stat(1'h0, 1'h0, 1'h1);
    end
  endtask
  // Alert response is refused while the line is high
  task automatic t_ara();
    host.ara(w[7:0], ok);
    chk1("ara idle", 1'h0, ok);
    wr_ok(CSWF_CMD_MODE, 16'h0001);
    chk1("irq", 1'h0, irq_n);
    host.ara(w[7:0], ok);
    chk1("ara ack", 1'h1, ok);
    chk("ara", {8'h00, CSWF_ARA_REPLY}, {8'h00, w[7:0]});
    chk1("irq", 1'h1, irq_n);
  endtask

  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge mclk_in);
    #1 rst_in = 1'h0;
    repeat (4) @(posedge mclk_in);
    chk1("irq", 1'h1, irq_n);
    t_caps();
    t_mode();
    t_pair();
    t_sens();
    t_ara();
    complete_run();
  end
  // About 29 word transfers of at most some 620 clocks each fit well inside
  initial begin
    repeat (60000) @(posedge mclk_in);
    n_mismatch++;
    complete_run();
  end
endmodule

`default_nettype wire
